// [rtl/rrio_pkg.sv]
// constants shared by both ends of the remote io link
// assumes one 40 mhz clock for both ends and an apb master on the host side
package rrio_pkg;
	localparam int SLOT_COUNT  = 32;
	localparam int VALUE_WIDTH = 16;

	// edge-type dedicated lines, one bit each on the edge bus
	localparam int EDGE_ERROR_CLEAR       = 0;
	localparam int EDGE_CYCLE_HALT        = 1;
	localparam int EDGE_SERVO_ENABLE      = 2;
	localparam int EDGE_MOTION_LOCK       = 3;
	localparam int EDGE_RETREAT_REQUEST   = 4;
	localparam int EDGE_OUTPUT_CLEAR      = 5;
	localparam int EDGE_PROGRAM_SELECT    = 6;
	localparam int EDGE_OVERRIDE_SELECT   = 7;
	localparam int EDGE_PROGRAM_NUMBER_RQ = 8;
	localparam int EDGE_COUNT             = 9;

	// level-type dedicated lines
	localparam int LEVEL_SERVO_DISABLE    = 0;
	localparam int LEVEL_OPERATION_RIGHTS = 1;
	localparam int LEVEL_COUNT            = 2;

	// status lines returned by the device
	localparam int STAT_ERROR       = 0;
	localparam int STAT_CYCLE_STOP  = 1;
	localparam int STAT_SERVO_OFF   = 2;
	localparam int STAT_SERVO_ON    = 3;
	localparam int STAT_RIGHTS      = 4;
	localparam int STAT_LOCK        = 5;
	localparam int STAT_RETREAT     = 6;
	localparam int STAT_EMERGENCY   = 7;
	localparam int STAT_PROGRAM_OUT = 8;
	localparam int STAT_COUNT       = 9;

	// host apb register map, byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_PULSE      = 8'h04;
	localparam logic [7:0] REG_VALUE      = 8'h08;
	localparam logic [7:0] REG_SLOT_START = 8'h0c;
	localparam logic [7:0] REG_SLOT_HALT  = 8'h10;
	localparam logic [7:0] REG_STATUS     = 8'h14;
	localparam logic [7:0] REG_RUNNING    = 8'h18;
	localparam logic [7:0] REG_WAIT       = 8'h1c;
	localparam logic [7:0] REG_NUMERIC    = 8'h20;
	localparam logic [7:0] REG_BUSY       = 8'h24;
	localparam int         CTRL_SERVO_DISABLE = 0;
	localparam int         CTRL_RIGHTS        = 1;

	// host strobe timing
	localparam int CLK_MHZ      = 40;
	localparam int SETUP_NS     = 1000;
	localparam int HOLD_NS      = 1000;
	localparam int GAP_NS       = 1000;
	localparam int COUNT_WIDTH  = 8;
	localparam int SETUP_CYCLES = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYCLES  = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYCLES   = (GAP_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		RRIO_IDLE  = 2'b00,
		RRIO_SETUP = 2'b01,
		RRIO_HIGH  = 2'b10,
		RRIO_GAP   = 2'b11
	} rrio_seq_t;
endpackage

// [rtl/rrio_link_if.sv]
// dedicated input/output wires between the external sequencer and the device
// assumes both ends are clocked by their own clk_in; the wires carry no clock
`timescale 1ns/100ps
`default_nettype none
interface rrio_link_if #(
	parameter int SLOTS = rrio_pkg::SLOT_COUNT,
	parameter int WIDTH = rrio_pkg::VALUE_WIDTH
);
	logic [rrio_pkg::EDGE_COUNT-1:0]  edge_line;
	logic [rrio_pkg::LEVEL_COUNT-1:0] level_line;
	logic [SLOTS-1:0]                 slot_start;
	logic [SLOTS-1:0]                 slot_halt;
	logic [WIDTH-1:0]                 numeric_value_bus_set;
	logic [rrio_pkg::STAT_COUNT-1:0]  status_line;
	logic [SLOTS-1:0]                 slot_running;
	logic [SLOTS-1:0]                 slot_wait;
	logic [WIDTH-1:0]                 numeric_value_bus_get;

	modport device (
		input  edge_line, level_line, slot_start, slot_halt, numeric_value_bus_set,
		output status_line, slot_running, slot_wait, numeric_value_bus_get
	);
	modport host (
		output edge_line, level_line, slot_start, slot_halt, numeric_value_bus_set,
		input  status_line, slot_running, slot_wait, numeric_value_bus_get
	);
endinterface
`default_nettype wire

// [rtl/rrio_host_end.sv]
// external sequencer end: apb registers turned into level and strobe lines
// assumes a zero-wait apb master on clk_in and the device end on the link
`timescale 1ns/100ps
`default_nettype none
module rrio_host_end #(
	parameter int SLOTS = rrio_pkg::SLOT_COUNT,
	parameter int WIDTH = rrio_pkg::VALUE_WIDTH
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	rrio_link_if.host        link
);
	localparam int SYNC_W      = rrio_pkg::STAT_COUNT + 2 * SLOTS + WIDTH;
	localparam int COUNT_WIDTH = rrio_pkg::COUNT_WIDTH;

	rrio_pkg::rrio_seq_t            state, next_state;
	logic [rrio_pkg::COUNT_WIDTH-1:0] count, next_count;
	logic [rrio_pkg::EDGE_COUNT-1:0] edge_mask, next_edge_mask;
	logic [SLOTS-1:0]               start_mask, next_start_mask;
	logic [rrio_pkg::EDGE_COUNT-1:0] edge_drive, next_edge_drive;
	logic [SLOTS-1:0]               start_drive, next_start_drive;
	logic [rrio_pkg::LEVEL_COUNT-1:0] ctrl, next_ctrl;
	logic [WIDTH-1:0]               value, next_value;
	logic [SLOTS-1:0]               halt, next_halt;
	logic [SYNC_W-1:0]              meta, sync;
	logic                           wr, known;

	// status from the device crosses as if from pins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= {link.numeric_value_bus_get, link.slot_wait, link.slot_running, link.status_line};
			sync <= meta;
		end
	end

	assign wr          = psel_in & penable_in & pwrite_in;
	assign pready_out  = 1'b1; // every access completes in its first access cycle
	assign known       = (paddr_in <= rrio_pkg::REG_BUSY) && (paddr_in[1:0] == 2'b00);
	assign pslverr_out = psel_in & penable_in & ~known;

	// read mux over registered state
	always_comb begin
		prdata_out = 32'h0000_0000;
		if (paddr_in == rrio_pkg::REG_CTRL) begin
			prdata_out[rrio_pkg::LEVEL_COUNT-1:0] = ctrl;
		end else if (paddr_in == rrio_pkg::REG_VALUE) begin
			prdata_out[WIDTH-1:0] = value;
		end else if (paddr_in == rrio_pkg::REG_SLOT_HALT) begin
			prdata_out[SLOTS-1:0] = halt;
		end else if (paddr_in == rrio_pkg::REG_STATUS) begin
			prdata_out[rrio_pkg::STAT_COUNT-1:0] = sync[rrio_pkg::STAT_COUNT-1:0];
		end else if (paddr_in == rrio_pkg::REG_RUNNING) begin
			prdata_out[SLOTS-1:0] = sync[rrio_pkg::STAT_COUNT +: SLOTS];
		end else if (paddr_in == rrio_pkg::REG_WAIT) begin
			prdata_out[SLOTS-1:0] = sync[rrio_pkg::STAT_COUNT + SLOTS +: SLOTS];
		end else if (paddr_in == rrio_pkg::REG_NUMERIC) begin
			prdata_out[WIDTH-1:0] = sync[rrio_pkg::STAT_COUNT + 2 * SLOTS +: WIDTH];
		end else if (paddr_in == rrio_pkg::REG_BUSY) begin
			prdata_out[0] = (state != rrio_pkg::RRIO_IDLE);
		end
	end

	// strobe sequencer: value settles before the line rises, line held long
	// enough for the device's synchroniser, then a gap before the next one
	always_comb begin
		next_state       = state;
		next_count       = count;
		next_edge_mask   = edge_mask;
		next_start_mask  = start_mask;
		next_ctrl        = ctrl;
		next_value       = value;
		next_halt        = halt;
		if (wr && paddr_in == rrio_pkg::REG_CTRL) begin
			next_ctrl = pwdata_in[rrio_pkg::LEVEL_COUNT-1:0]; // [RULE7]
		end else if (wr && paddr_in == rrio_pkg::REG_SLOT_HALT) begin
			next_halt = pwdata_in[SLOTS-1:0];
		end else if (wr && paddr_in == rrio_pkg::REG_VALUE && state == rrio_pkg::RRIO_IDLE) begin
			next_value = pwdata_in[WIDTH-1:0]; // [RULE16]
		end
		case (state)
			rrio_pkg::RRIO_IDLE: begin
				if (wr && (paddr_in == rrio_pkg::REG_PULSE || paddr_in == rrio_pkg::REG_SLOT_START)) begin
					next_edge_mask  = (paddr_in == rrio_pkg::REG_PULSE) ? pwdata_in[rrio_pkg::EDGE_COUNT-1:0] : '0;
					next_start_mask = (paddr_in == rrio_pkg::REG_SLOT_START) ? pwdata_in[SLOTS-1:0] : '0;
					next_count      = COUNT_WIDTH'(rrio_pkg::SETUP_CYCLES);
					next_state      = rrio_pkg::RRIO_SETUP;
				end
			end
			rrio_pkg::RRIO_SETUP: begin
				next_count = count - 1'b1;
				if (count == 1) begin
					next_count = COUNT_WIDTH'(rrio_pkg::HOLD_CYCLES);
					next_state = rrio_pkg::RRIO_HIGH; // [RULE14] [RULE15]
				end
			end
			rrio_pkg::RRIO_HIGH: begin
				next_count = count - 1'b1;
				if (count == 1) begin
					next_count = COUNT_WIDTH'(rrio_pkg::GAP_CYCLES);
					next_state = rrio_pkg::RRIO_GAP;
				end
			end
			default: begin
				next_count = count - 1'b1;
				if (count == 1) begin
					next_state = rrio_pkg::RRIO_IDLE;
				end
			end
		endcase
		next_edge_drive  = (next_state == rrio_pkg::RRIO_HIGH) ? next_edge_mask : '0;
		next_start_drive = (next_state == rrio_pkg::RRIO_HIGH) ? next_start_mask : '0;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state       <= rrio_pkg::RRIO_IDLE;
			count       <= '0;
			edge_mask   <= '0;
			start_mask  <= '0;
			edge_drive  <= '0;
			start_drive <= '0;
			ctrl        <= '0;
			value       <= '0;
			halt        <= '0;
		end else begin
			state       <= next_state;
			count       <= next_count;
			edge_mask   <= next_edge_mask;
			start_mask  <= next_start_mask;
			edge_drive  <= next_edge_drive;
			start_drive <= next_start_drive;
			ctrl        <= next_ctrl;
			value       <= next_value;
			halt        <= next_halt;
		end
	end

	assign link.edge_line             = edge_drive;
	assign link.slot_start            = start_drive;
	assign link.level_line            = ctrl;
	assign link.slot_halt             = halt;
	assign link.numeric_value_bus_set = value;
endmodule
`default_nettype wire

// [rtl/rrio_device_end.sv]
// robot controller end of the dedicated remote io: command interpreter
// assumes the link wires come from another domain and the motion core
// reports events on the plain user-side ports, all on clk_in
//
// Operation
// RULE1: level inputs act only while held on
// RULE2: edge inputs act on off-to-on, then hold
// RULE3: error clear edge clears error; error shown
// RULE4: cycle halt edge starts cycle stop, shown
// RULE5: servo disable level forces servos off, echoed
// RULE6: servo enable edge turns servos on, shown
// RULE7: rights level requested; rights valid shown
// RULE8: motion lock edge toggles lock, state shown
// RULE9: retreat edge starts evasion return, shown
// RULE10: output clear edge resets general outputs
// RULE11: emergency indication while emergency has occurred
// RULE12: each slot start edge starts that slot
// RULE13: slot halt level stops slot, wait shown
// RULE14: program select edge latches numeric value
// RULE15: override select edge latches override value
// RULE16: numeric groups span configured width, level sampled
// RULE17: program request edge outputs program, indicator
// RULE18: inputs synchronised, edges from sample compare
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rrio_device_end #(
	parameter int SLOTS = rrio_pkg::SLOT_COUNT,
	parameter int WIDTH = rrio_pkg::VALUE_WIDTH
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	rrio_link_if.device           link,
	input  wire logic             rights_permit_in,
	input  wire logic             error_event_in,
	input  wire logic             emergency_in,
	input  wire logic             cycle_end_in,
	input  wire logic             retreat_done_in,
	input  wire logic [SLOTS-1:0] slot_done_in,
	output logic                  servo_on_out,
	output logic                  motion_lock_out,
	output logic                  cycle_stop_out,
	output logic                  retreat_active_out,
	output logic [SLOTS-1:0]      slot_running_out,
	output logic [SLOTS-1:0]      slot_wait_out,
	output logic                  general_output_clear_out,
	output logic [WIDTH-1:0]      program_selection_out,
	output logic [WIDTH-1:0]      override_value_out
);
	localparam int EC     = rrio_pkg::EDGE_COUNT;
	localparam int LC     = rrio_pkg::LEVEL_COUNT;
	localparam int SYNC_W = EC + LC + 2 * SLOTS + WIDTH;

	logic [SYNC_W-1:0] raw, meta, sync, prev;
	logic [EC-1:0]     edge_now, edge_old, edge_rise;
	logic [LC-1:0]     level_now;
	logic [SLOTS-1:0]  start_now, start_old, start_rise;
	logic [SLOTS-1:0]  halt_now;
	logic [WIDTH-1:0]  value_now;
	logic              rights_valid;
	logic [EC-1:0]     cmd;

	logic             error, next_error;
	logic             emergency, next_emergency;
	logic             cycle_stop, next_cycle_stop;
	logic             servo_on, next_servo_on;
	logic             lock, next_lock;
	logic             retreat, next_retreat;
	logic             gpo_clear, next_gpo_clear;
	logic             prog_out, next_prog_out;
	logic [WIDTH-1:0] prog_id, next_program;
	logic [WIDTH-1:0] override, next_override;
	logic [SLOTS-1:0] running, next_running;

	assign raw = {link.numeric_value_bus_set, link.slot_halt, link.slot_start, link.level_line, link.edge_line};

	// two-stage synchroniser plus one previous sample for edge detection;
	// meta feeds only sync so a metastable level never reaches logic
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
		end else begin
			meta <= raw; // [RULE18]
			sync <= meta;
			prev <= sync;
		end
	end

	// split the sampled vector back into its groups
	assign edge_now  = sync[0 +: EC];
	assign edge_old  = prev[0 +: EC];
	assign level_now = sync[EC +: LC];
	assign start_now = sync[EC + LC +: SLOTS];
	assign start_old = prev[EC + LC +: SLOTS];
	assign halt_now  = sync[EC + LC + SLOTS +: SLOTS];
	assign value_now = sync[EC + LC + 2 * SLOTS +: WIDTH]; // [RULE16]

	// off-to-on detection; a line held high fires only once
	assign edge_rise  = edge_now & ~edge_old;   // [RULE2] [RULE18]
	assign start_rise = start_now & ~start_old; // [RULE2]

	// edge commands and slot starts count only while the sequencer holds the rights
	// and the controller side permits remote operation
	assign rights_valid = level_now[rrio_pkg::LEVEL_OPERATION_RIGHTS] & rights_permit_in; // [RULE7] [RULE1]
	assign cmd          = rights_valid ? edge_rise : '0;

	// controller state; every hardware set wins over a same-cycle clear
	always_comb begin
		next_error      = error;
		next_emergency  = emergency;
		next_cycle_stop = cycle_stop;
		next_servo_on   = servo_on;
		next_lock       = lock;
		next_retreat    = retreat;
		next_prog_out   = prog_out;
		next_program    = prog_id;
		next_override   = override;
		next_running    = running;

		if (cmd[rrio_pkg::EDGE_ERROR_CLEAR]) begin
			next_error     = 1'b0; // [RULE3]
			next_emergency = 1'b0;
		end
		if (error_event_in) begin
			next_error = 1'b1; // [RULE3]
		end
		// the safety circuit level sets the flag; it stays up until an error clear edge after release
		if (emergency_in) begin
			next_emergency = 1'b1; // [RULE11]
		end

		if (cycle_end_in) begin
			next_cycle_stop = 1'b0;
		end
		if (cmd[rrio_pkg::EDGE_CYCLE_HALT]) begin
			next_cycle_stop = 1'b1; // [RULE4]
		end

		// disable is a level and not gated by rights, for safety
		if (level_now[rrio_pkg::LEVEL_SERVO_DISABLE] || next_emergency) begin
			next_servo_on = 1'b0; // [RULE5] [RULE1]
		end else if (cmd[rrio_pkg::EDGE_SERVO_ENABLE]) begin
			next_servo_on = 1'b1; // [RULE6]
		end

		if (cmd[rrio_pkg::EDGE_MOTION_LOCK]) begin
			next_lock = ~lock; // [RULE8]
		end

		if (retreat_done_in || !next_servo_on) begin
			next_retreat = 1'b0;
		end
		if (cmd[rrio_pkg::EDGE_RETREAT_REQUEST] && next_servo_on) begin
			next_retreat = 1'b1; // [RULE9]
		end

		if (cmd[rrio_pkg::EDGE_PROGRAM_SELECT]) begin
			next_program  = value_now; // [RULE14]
			next_prog_out = 1'b0;
		end
		if (cmd[rrio_pkg::EDGE_OVERRIDE_SELECT]) begin
			next_override = value_now; // [RULE15]
		end
		if (cmd[rrio_pkg::EDGE_PROGRAM_NUMBER_RQ]) begin
			next_prog_out = 1'b1; // [RULE17]
		end

		// a finished cycle stop ends every running slot
		if (cycle_end_in && cycle_stop) begin
			next_running = '0;
		end
		next_running = next_running & ~slot_done_in;
		if (rights_valid && servo_on && !error) begin
			next_running = next_running | start_rise; // [RULE12]
		end
		if (!next_servo_on) begin
			next_running = '0;
		end
	end

	// general output reset is a one-cycle pulse to the output block
	assign next_gpo_clear = cmd[rrio_pkg::EDGE_OUTPUT_CLEAR]; // [RULE10]

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			error      <= 1'b0;
			emergency  <= 1'b0;
			cycle_stop <= 1'b0;
			servo_on   <= 1'b0;
			lock       <= 1'b0;
			retreat    <= 1'b0;
			gpo_clear  <= 1'b0;
			prog_out   <= 1'b0;
			prog_id    <= '0;
			override   <= '0;
			running    <= '0;
		end else begin
			error      <= next_error;
			emergency  <= next_emergency;
			cycle_stop <= next_cycle_stop;
			servo_on   <= next_servo_on;
			lock       <= next_lock;
			retreat    <= next_retreat;
			gpo_clear  <= next_gpo_clear;
			prog_out   <= next_prog_out;
			prog_id    <= next_program;
			override   <= next_override;
			running    <= next_running;
		end
	end

	logic [rrio_pkg::STAT_COUNT-1:0] next_status, status;
	logic [SLOTS-1:0]                next_wait, wait_q;
	logic [WIDTH-1:0]                next_numeric, numeric;

	// status word for the link, registered so the lines never glitch
	always_comb begin
		next_status                            = '0;
		next_status[rrio_pkg::STAT_ERROR]      = next_error;                                // [RULE3]
		next_status[rrio_pkg::STAT_CYCLE_STOP] = next_cycle_stop;                           // [RULE4]
		next_status[rrio_pkg::STAT_SERVO_OFF]  = level_now[rrio_pkg::LEVEL_SERVO_DISABLE];  // [RULE5]
		next_status[rrio_pkg::STAT_SERVO_ON]   = next_servo_on;                             // [RULE6]
		next_status[rrio_pkg::STAT_RIGHTS]     = rights_valid;                              // [RULE7]
		next_status[rrio_pkg::STAT_LOCK]       = next_lock;                                 // [RULE8]
		next_status[rrio_pkg::STAT_RETREAT]    = next_retreat;                              // [RULE9]
		next_status[rrio_pkg::STAT_EMERGENCY]  = next_emergency;                            // [RULE11]
		next_status[rrio_pkg::STAT_PROGRAM_OUT] = next_prog_out;                            // [RULE17]
		next_wait    = next_running & halt_now;            // [RULE13] [RULE1]
		next_numeric = next_prog_out ? next_program : '0;  // [RULE17]
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status  <= '0;
			wait_q  <= '0;
			numeric <= '0;
		end else begin
			status  <= next_status;
			wait_q  <= next_wait;
			numeric <= next_numeric;
		end
	end

	// link and controller-side outputs
	assign link.status_line           = status;
	assign link.slot_running          = running & ~wait_q; // halted slot shows wait, not operating
	assign link.slot_wait             = wait_q;
	assign link.numeric_value_bus_get = numeric;
	assign servo_on_out               = servo_on;
	assign motion_lock_out            = lock;
	assign cycle_stop_out             = cycle_stop;
	assign retreat_active_out         = retreat;
	assign slot_running_out           = running & ~wait_q; // [RULE13]
	assign slot_wait_out              = wait_q;
	assign general_output_clear_out   = gpo_clear;
	assign program_selection_out      = prog_id;
	assign override_value_out         = override;
endmodule
`default_nettype wire

// [bench/rrio_link_sva.sv]
// checker on the link wires between the host end and the device end
// assumes the bench clock and reset; instantiated beside the link
`timescale 1ns/100ps
`default_nettype none
module rrio_link_sva #(
	parameter int SLOTS = 32,
	parameter int WIDTH = 16
) (
	input wire logic             clk_in,
	input wire logic             rst_b_in,
	input wire logic [8:0]       edge_line,
	input wire logic [1:0]       level_line,
	input wire logic [SLOTS-1:0] slot_halt,
	input wire logic [8:0]       status_line,
	input wire logic [SLOTS-1:0] slot_running,
	input wire logic [SLOTS-1:0] slot_wait,
	input wire logic [WIDTH-1:0] numeric_value_bus_get
);
	// cycles since each strobe was high, saturating so stale strobes never excuse a change
	logic [3:0] since      [9];
	logic [3:0] next_since [9];
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			next_since[i] = edge_line[i] ? 4'h0 : since[i] + {3'h0, since[i] != 4'hf};
		end
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			since <= '{default: 4'hf};
		end else begin
			since <= next_since;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// servo disable held long enough to cross the synchroniser
	sequence s_off_held; level_line[0] [*8]; endsequence
	property p_echo; $stable(level_line[0]) [*6] |-> status_line[2] == level_line[0]; endproperty
	a_echo: assert property (p_echo) else $error("servo disable echo wrong");
	property p_off; s_off_held |-> !status_line[3]; endproperty
	a_off: assert property (p_off) else $error("servo on while disabled");
	property p_rights; (!level_line[1]) [*8] |-> !status_line[4]; endproperty
	a_rights: assert property (p_rights) else $error("rights shown without request");
	property p_excl; (slot_running & slot_wait) == '0; endproperty
	a_excl: assert property (p_excl) else $error("slot running and waiting");
	// wait may only show where the halt line stood three samples earlier
	property p_wait; (slot_wait & ~$past(slot_halt, 3)) == '0; endproperty
	a_wait: assert property (p_wait) else $error("slot waiting without halt");
	property p_idle; !status_line[8] && !$past(status_line[8]) |-> numeric_value_bus_get == '0; endproperty
	a_idle: assert property (p_idle) else $error("numeric output without request");
	property p_clr; $fell(status_line[0]) |-> since[0] <= 4'h8; endproperty
	a_clr: assert property (p_clr) else $error("error dropped without clear strobe");
	property p_son; $rose(status_line[3]) |-> since[2] <= 4'h8; endproperty
	a_son: assert property (p_son) else $error("servo on without enable strobe");
	property p_lock; $changed(status_line[5]) |-> since[3] <= 4'h8; endproperty
	a_lock: assert property (p_lock) else $error("lock changed without strobe");
	property p_prg; $rose(status_line[8]) |-> since[8] <= 4'h8; endproperty
	a_prg: assert property (p_prg) else $error("program output without request");
endmodule
`default_nettype wire

// [bench/robot_remote_io_control_tb_top.sv]
// bench: apb master on the host end, device end user side driven and watched
// assumes package, link, both ends and the link checker compile first
`timescale 1ns/100ps
`default_nettype none
module robot_remote_io_control_tb_top;
	logic        clk_in   = 0;
	logic        rst_b_in = 0;
	logic        psel     = 0;
	logic        penable  = 0;
	logic        pwrite   = 0;
	logic [7:0]  paddr    = 0;
	logic [31:0] pwdata   = 0;
	logic [3:0]  usr      = 0;
	logic        permit   = 1;
	logic [31:0] prdata, rd, m, h, v, running, waiting;
	logic        pready, pslverr, son, lock, cstop, retreat, oclr;
	logic [15:0] prg, ovr;
	logic [33:0] q[$];
	logic [33:0] e;
	int          n_mismatch = 0;
	int          n_tests    = 0;
	int          n_clr      = 0;
	int          cyc        = 0;
	always #12.5 clk_in = ~clk_in;
	rrio_link_if link ();
	rrio_host_end rrio_host_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .link(link.host));
	rrio_device_end rrio_device_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link.device),
		.rights_permit_in(permit), .error_event_in(usr[0]), .emergency_in(usr[1]), .cycle_end_in(usr[2]),
		.retreat_done_in(usr[3]), .slot_done_in('0), .servo_on_out(son), .motion_lock_out(lock),
		.cycle_stop_out(cstop), .retreat_active_out(retreat), .slot_running_out(running),
		.slot_wait_out(waiting), .general_output_clear_out(oclr), .program_selection_out(prg),
		.override_value_out(ovr));
	rrio_link_sva rrio_link_sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .edge_line(link.edge_line),
		.level_line(link.level_line), .slot_halt(link.slot_halt), .status_line(link.status_line),
		.slot_running(link.slot_running), .slot_wait(link.slot_wait),
		.numeric_value_bus_get(link.numeric_value_bus_get));
	task automatic final_report;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// note bit 33 asks for a data check, bit 32 is the expected error flag
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
		q.push_back(x);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in) penable <= 1;
		do @(posedge clk_in); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge clk_in);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0, {2'b10, x});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d, 34'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// strobe writes are ignored while busy, so poll it out before moving on
	task automatic go(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		rd = 1;
		for (int i = 0; i < 100 && rd[0]; i++) apb(0, rrio_pkg::REG_BUSY, 0, 34'h0);
		wt(6);
	endtask
	task automatic pulse(input int b);
		go(rrio_pkg::REG_PULSE, 32'h1 << b);
	endtask
	task automatic ev(input int b);
		usr[b] <= 1;
		wt(1);
		usr[b] <= 0;
		wt(8);
	endtask
	// scoreboard: every finished transfer takes the oldest note
	always @(posedge clk_in) begin
		if (psel && penable && pready && q.size() > 0) begin
			e = q.pop_front();
			chk(32'(pslverr), 32'(e[32]));
			if (e[33]) chk(prdata, e[31:0]);
		end
	end
	// hang guard and one-cycle pulse counter
	always @(posedge clk_in) begin
		cyc++;
		if (oclr === 1'b1) n_clr++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report;
		end
	end
	initial begin
		v = $urandom(32'h9caf);
		wt(12);
		rst_b_in <= 1;
		wt(4);
		rdc(rrio_pkg::REG_CTRL, 0);
		rdc(rrio_pkg::REG_STATUS, 0);
		apb(1, 8'h28, 0, {2'b01, 32'h0});
		apb(1, 8'h06, 0, {2'b01, 32'h0});
		pulse(rrio_pkg::EDGE_MOTION_LOCK);
		chk(32'(lock), 0);
		wr(rrio_pkg::REG_CTRL, 32'h2);
		wt(10);
		rdc(rrio_pkg::REG_STATUS, 32'h10);
		pulse(rrio_pkg::EDGE_SERVO_ENABLE);
		chk(32'(son), 1);
		pulse(rrio_pkg::EDGE_MOTION_LOCK);
		chk(32'(lock), 1);
		rdc(rrio_pkg::REG_STATUS, 32'h38);
		pulse(rrio_pkg::EDGE_MOTION_LOCK);
		chk(32'(lock), 0);
		m = $urandom;
		go(rrio_pkg::REG_SLOT_START, m);
		rdc(rrio_pkg::REG_RUNNING, m);
		h = $urandom;
		wr(rrio_pkg::REG_SLOT_HALT, h);
		wt(10);
		chk(waiting, m & h);
		rdc(rrio_pkg::REG_WAIT, m & h);
		wr(rrio_pkg::REG_SLOT_HALT, 0);
		wt(10);
		chk(running, m);
		pulse(rrio_pkg::EDGE_CYCLE_HALT);
		chk({cstop, running[30:0]}, {1'b1, m[30:0]});
		ev(2);
		chk({cstop, running[30:0]}, 0);
		pulse(rrio_pkg::EDGE_RETREAT_REQUEST);
		chk(32'(retreat), 1);
		ev(3);
		chk(32'(retreat), 0);
		pulse(rrio_pkg::EDGE_OUTPUT_CLEAR);
		chk(n_clr, 1);
		wr(rrio_pkg::REG_VALUE, {16'h0, v[15:0]});
		pulse(rrio_pkg::EDGE_PROGRAM_SELECT);
		wr(rrio_pkg::REG_VALUE, {16'h0, h[15:0]});
		pulse(rrio_pkg::EDGE_OVERRIDE_SELECT);
		chk({prg, ovr}, {v[15:0], h[15:0]});
		pulse(rrio_pkg::EDGE_PROGRAM_NUMBER_RQ);
		rdc(rrio_pkg::REG_STATUS, 32'h118);
		rdc(rrio_pkg::REG_NUMERIC, {16'h0, v[15:0]});
		ev(0);
		rdc(rrio_pkg::REG_STATUS, 32'h119);
		go(rrio_pkg::REG_SLOT_START, m);
		chk(running, 0);
		pulse(rrio_pkg::EDGE_ERROR_CLEAR);
		rdc(rrio_pkg::REG_STATUS, 32'h118);
		ev(1);
		rdc(rrio_pkg::REG_STATUS, 32'h190);
		pulse(rrio_pkg::EDGE_ERROR_CLEAR);
		rdc(rrio_pkg::REG_STATUS, 32'h110);
		pulse(rrio_pkg::EDGE_SERVO_ENABLE);
		wr(rrio_pkg::REG_CTRL, 32'h3);
		wt(10);
		rdc(rrio_pkg::REG_STATUS, 32'h114);
		pulse(rrio_pkg::EDGE_SERVO_ENABLE);
		chk(32'(son), 0);
		wr(rrio_pkg::REG_CTRL, 32'h2);
		wt(10);
		rdc(rrio_pkg::REG_STATUS, 32'h110);
		permit <= 0;
		wt(10);
		rdc(rrio_pkg::REG_STATUS, 32'h100);
		final_report;
	end
endmodule
`default_nettype wire
